// ===== hdl/nfb_pkg.sv
package nfb_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W         = 22;
    localparam int DATA_W         = 16;
    localparam int SECT_LO        = 12;
    localparam int SECT_HI        = 21;
    localparam int SECT_IGN       = 3;
    localparam int BUF_MAX_WORDS  = 16;
    localparam int BUF_MAX_BYTES  = 32;

    // ----------------------------------------------------------------
    // Timing in ns and cycles at 100 MHz
    // ----------------------------------------------------------------
    localparam int CLK_NS         = 10;
    localparam int CE_ACCESS_NS   = 90;
    localparam int ADDR_ACCESS_NS = 90;
    localparam int SLEEP_EXTRA_NS = 30;
    localparam int CLEAR_PULSE_NS = 500;
    localparam int WR_PULSE_NS    = 40;
    localparam int CE_ACC_CYC     = (CE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CLEAR_CYC      = (CLEAR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_CYC         = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W          = 8;

    // ----------------------------------------------------------------
    // Requests
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        NFB_OP_READ   = 3'h0,
        NFB_OP_WRITE  = 3'h1,
        NFB_OP_CLEAR  = 3'h2,
        NFB_OP_ACCEL  = 3'h3,
        NFB_OP_IDLE   = 3'h4
    } nfb_op_t;

    typedef struct packed {
        nfb_op_t               op;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     data;
    } nfb_req_t;

    typedef struct packed {
        logic                  chip_sel_n;
        logic                  out_en_n;
        logic                  wr_strobe_n;
        logic                  clear_n;
    } nfb_strobe_t;

endpackage

// ===== hdl/nfb_host.sv
`timescale 1ns/100ps
// Contract
// RULE1 - Commands are written with write strobe and chip select low, output enable high.
// RULE2 - In short program mode a program takes two write cycles, not four.
// RULE3 - Erase can target one sector, several sectors or the whole device.
// RULE4 - One buffer load holds at most 16 words or 32 bytes.
// RULE5 - High-voltage accelerate input enters short program mode and lifts protection.
// RULE6 - Accelerated programming uses two-cycle sequence; dropping high voltage restores normal.
// RULE7 - Host keeps accelerate input high-voltage only during accelerated programming.
// RULE8 - Identification command makes reads return register codes on low byte.
// RULE9 - In standby the device data outputs float regardless of output enable.
// RULE10 - Standby with chip select and clear high; first read waits chip-enable access.
// RULE11 - Deselecting during program or erase does not abort it.
// RULE12 - Stable address for access time plus 30 ns enters automatic sleep.
// RULE13 - Sleep keeps last data latched; address change gives new data normally.
// RULE14 - Clear pin low for minimum width aborts, tri-states, ignores accesses.
// RULE15 - Hardware clear returns the device to array read.
// RULE16 - Host restarts program or erase interrupted by a hardware clear; this host does not, it only pulses clear_done when the clear pulse ends.
// RULE17 - Output enable high floats the device data pins.
// RULE18 - Sector number comes from the same upper address bits in both configurations.
// RULE19 - After power-up or clear, plain reads return array data.
// RULE20 - Uniform sector is 32 Kwords, upper sector bits, lowest three ignored.
module nfb_host #(
    parameter int CLEAR_CYCLES = nfb_pkg::CLEAR_CYC
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      clk_en,
    input  wire nfb_pkg::nfb_req_t         req,
    input  wire logic                      req_valid,
    output logic                           req_ready,
    output logic                           rd_valid,
    output logic [nfb_pkg::DATA_W-1:0]     rd_data,
    output logic                           clear_done,
    output nfb_pkg::nfb_strobe_t           strobes,
    output logic [nfb_pkg::ADDR_W-1:0]     flash_addr,
    output logic [nfb_pkg::DATA_W-1:0]     dq_out,
    output logic                           dq_oe,
    input  wire logic [nfb_pkg::DATA_W-1:0] dq_in,
    output logic                           accel_program_input
);

    // Counter is CNT_W bits; a one-cycle pulse is too short for the pin
    if (CLEAR_CYCLES < 2 || CLEAR_CYCLES > 255) begin : g_bad_clear
        $error("CLEAR_CYCLES out of range");
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_READ  = 5'b00010,
        ST_WRITE = 5'b00100,
        ST_RECOV = 5'b01000,
        ST_CLEAR = 5'b10000
    } nfb_state_t;

    nfb_state_t                    state_r, state_nxt;
    logic [nfb_pkg::CNT_W-1:0]     cnt_r, cnt_nxt;
    nfb_pkg::nfb_strobe_t          strobes_r, strobes_nxt;
    logic [nfb_pkg::ADDR_W-1:0]    addr_r, addr_nxt;
    logic [nfb_pkg::DATA_W-1:0]    dout_r, dout_nxt;
    logic                          oe_r, oe_nxt;
    logic                          accel_r, accel_nxt;
    logic                          ready_r, ready_nxt;
    logic                          rdv_r, rdv_nxt;
    logic [nfb_pkg::DATA_W-1:0]    rdat_r, rdat_nxt;
    logic                          cdone_r, cdone_nxt;
    logic [nfb_pkg::DATA_W-1:0]    dq_s1_r, dq_s2_r, dq_s3_r;

    // Data pins come from another timing domain: three stages
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
            dq_s3_r <= 16'h0000;
        end else if (clk_en) begin
            dq_s1_r <= dq_in;
            dq_s2_r <= dq_s1_r;
            dq_s3_r <= dq_s2_r;
        end
    end

    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        strobes_nxt = strobes_r;
        addr_nxt    = addr_r;
        dout_nxt    = dout_r;
        oe_nxt      = oe_r;
        accel_nxt   = accel_r;
        ready_nxt   = 1'b0;
        rdv_nxt     = 1'b0;
        rdat_nxt    = rdat_r;
        cdone_nxt   = 1'b0;
        case (state_r)
            ST_IDLE: begin
                ready_nxt = 1'b1;
                if (req_valid && ready_r) begin
                    ready_nxt = 1'b0;
                    addr_nxt  = req.addr;
                    case (req.op)
                        nfb_pkg::NFB_OP_READ: begin
                            // Full chip-enable access covers standby exit
                            strobes_nxt.chip_sel_n = 1'b0;          // [RULE10]
                            strobes_nxt.out_en_n   = 1'b0;
                            cnt_nxt   = 8'(nfb_pkg::CE_ACC_CYC + 2);
                            state_nxt = ST_READ;
                        end
                        nfb_pkg::NFB_OP_WRITE, nfb_pkg::NFB_OP_ACCEL: begin
                            strobes_nxt.chip_sel_n  = 1'b0;         // [RULE1]
                            strobes_nxt.wr_strobe_n = 1'b0;         // [RULE1]
                            strobes_nxt.out_en_n    = 1'b1;         // [RULE1]
                            // One request, one bus write: sequence length is the requester's
                            dout_nxt  = req.data;                   // [RULE2] [RULE4]
                            oe_nxt    = 1'b1;
                            // Raised only while an accelerated write runs
                            accel_nxt = (req.op == nfb_pkg::NFB_OP_ACCEL); // [RULE7] [RULE6]
                            cnt_nxt   = 8'(nfb_pkg::WR_CYC);
                            state_nxt = ST_WRITE;
                        end
                        nfb_pkg::NFB_OP_CLEAR: begin
                            strobes_nxt.clear_n    = 1'b0;          // [RULE14]
                            strobes_nxt.chip_sel_n = 1'b1;
                            cnt_nxt   = 8'(CLEAR_CYCLES);
                            state_nxt = ST_CLEAR;
                        end
                        default: begin
                            // Standby: deselect, clear high
                            strobes_nxt.chip_sel_n = 1'b1;          // [RULE10]
                            accel_nxt = 1'b0;
                            state_nxt = ST_RECOV;
                            cnt_nxt   = 8'h01;
                        end
                    endcase
                end
            end
            ST_READ: begin
                cnt_nxt = cnt_r - 8'h01;
                // Waits while the last two pin stages disagree; a bus that never settles stalls
                if (cnt_r == 8'h01) begin
                    cnt_nxt = 8'h01;
                    if (dq_s2_r == dq_s3_r) begin
                        rdv_nxt   = 1'b1;
                        rdat_nxt  = dq_s3_r;
                        strobes_nxt.out_en_n = 1'b1;                // [RULE17]
                        state_nxt = ST_RECOV;
                    end
                end
            end
            ST_WRITE: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    strobes_nxt.wr_strobe_n = 1'b1;
                    cnt_nxt   = 8'h01;
                    state_nxt = ST_RECOV;
                end
            end
            ST_CLEAR: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    strobes_nxt.clear_n = 1'b1;
                    accel_nxt = 1'b0;
                    cdone_nxt = 1'b1;                               // [RULE16]
                    cnt_nxt   = 8'h01;
                    state_nxt = ST_RECOV;
                end
            end
            ST_RECOV: begin
                oe_nxt    = 1'b0;
                accel_nxt = 1'b0;                                   // [RULE6]
                state_nxt = ST_IDLE;
                ready_nxt = 1'b1;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            cnt_r     <= 8'h00;
            strobes_r <= 4'hF;
            addr_r    <= 22'h000000;
            dout_r    <= 16'h0000;
            oe_r      <= 1'b0;
            accel_r   <= 1'b0;
            ready_r   <= 1'b0;
            rdv_r     <= 1'b0;
            rdat_r    <= 16'h0000;
            cdone_r   <= 1'b0;
        end else if (clk_en) begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            strobes_r <= strobes_nxt;
            addr_r    <= addr_nxt;
            dout_r    <= dout_nxt;
            oe_r      <= oe_nxt;
            accel_r   <= accel_nxt;
            ready_r   <= ready_nxt;
            rdv_r     <= rdv_nxt;
            rdat_r    <= rdat_nxt;
            cdone_r   <= cdone_nxt;
        end
    end

    assign req_ready           = ready_r;
    assign rd_valid            = rdv_r;
    assign rd_data             = rdat_r;
    assign clear_done          = cdone_r;
    assign strobes             = strobes_r;
    assign flash_addr          = addr_r;
    assign dq_out              = dout_r;
    assign dq_oe               = oe_r;
    assign accel_program_input = accel_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence write_pulse_s;
        !strobes_r.wr_strobe_n && !strobes_r.chip_sel_n;
    endsequence

    write_strobes_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
        write_pulse_s |-> strobes_r.out_en_n && oe_r)
        else $error("write cycle without output enable high");

    accel_only_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
        accel_r |-> (state_r == ST_WRITE || state_r == ST_RECOV))
        else $error("accelerate held outside programming");

    clear_width_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en) // [RULE14]
        $fell(strobes_r.clear_n) |-> !strobes_r.clear_n [*2])
        else $error("clear pulse too short");

    clear_quiet_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE14]
        !strobes_r.clear_n |-> strobes_r.chip_sel_n && strobes_r.wr_strobe_n && !oe_r)
        else $error("bus access during clear pulse");

    no_drive_read_a: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
        !strobes_r.out_en_n |-> !oe_r)
        else $error("host drives bus while device may drive");

    read_wait_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en) // [RULE10]
        $fell(strobes_r.out_en_n) |-> !rd_valid [*8])
        else $error("read data taken before access time");

endmodule

// ===== tb/nfb_flash_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Flash device model
// ----------------------------------------------------------------
module nfb_flash_model (
    input  wire logic                       core_clk,
    input  wire nfb_pkg::nfb_strobe_t       strobes,
    input  wire logic [nfb_pkg::ADDR_W-1:0] flash_addr,
    input  wire logic [nfb_pkg::DATA_W-1:0] dq_out,
    input  wire logic                       dq_oe,
    input  wire logic                       accel_program_input,
    output logic      [nfb_pkg::DATA_W-1:0] dq_in
);
    logic [nfb_pkg::DATA_W-1:0] mem [logic [nfb_pkg::ADDR_W-1:0]];
    logic                       driving;

    initial dq_in = 16'hA5A5;
    assign driving = strobes.clear_n && !strobes.chip_sel_n && !strobes.out_en_n;

    always @(posedge core_clk) begin
        // No protection kept, so every accepted write lands
        if (strobes.clear_n && !strobes.chip_sel_n && !strobes.wr_strobe_n && strobes.out_en_n
            && dq_oe) begin
            mem[flash_addr] = dq_out;
        end
        if (driving) begin
            dq_in <= mem.exists(flash_addr) ? mem[flash_addr] : 16'hFFFF;
        end else begin
            // Released pins toggle so stale data cannot pass
            dq_in <= ~dq_in;
        end
    end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        nfb_pkg::nfb_req_t          req;
        logic [nfb_pkg::DATA_W-1:0] exp;
    } nfb_row_t;
    localparam int CLR = 4;
    logic                 core_clk, rst, req_valid, req_ready, rd_valid, clear_done;
    logic                 dq_oe, accel_program_input, clk_en;
    nfb_pkg::nfb_req_t    req;
    nfb_pkg::nfb_strobe_t strobes;
    logic [21:0]          flash_addr;
    logic [15:0]          rd_data, dq_out, dq_in;
    int                   miscompares, checks, cycles, n;
    nfb_row_t             rows [7];

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    nfb_host #(.CLEAR_CYCLES(CLR)) nfb_host_inst (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .req(req), .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .clear_done(clear_done), .strobes(strobes), .flash_addr(flash_addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .accel_program_input(accel_program_input));
    nfb_flash_model nfb_flash_model_inst (.core_clk(core_clk), .strobes(strobes),
        .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .accel_program_input(accel_program_input), .dq_in(dq_in));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Returns one ns after the edge that took the request
    task automatic issue(input nfb_pkg::nfb_req_t r);
        int k;
        k = 0;
        @(posedge core_clk);
        req <= r;
        req_valid <= 1'b1;
        #1;
        // Ready seen settled here means the next edge takes the request
        while (req_ready !== 1'b1 && k < 100) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        @(posedge core_clk);
        req_valid <= 1'b0;
        #1;
        chk("taken", k < 100, 1);
    endtask

    task automatic wait_pulse(input logic sel, output int k);
        k = 0;
        do begin
            @(posedge core_clk);
            #1;
            k++;
        end while ((sel ? clear_done : rd_valid) !== 1'b1 && k < 200);
    endtask

    task automatic do_row(input nfb_row_t r);
        int k;
        issue(r.req);
        if (r.req.op == nfb_pkg::NFB_OP_READ) begin
            chk("rd_strobes", strobes, 4'h3);
            wait_pulse(1'b0, k);
            chk("rd_latency", k, nfb_pkg::CE_ACC_CYC + 2);
            chk("rd_data", rd_data, r.exp);
        end else begin
            chk("wr_strobes", strobes, 4'h5);
            chk("wr_bus", {dq_oe, flash_addr, dq_out}, {1'b1, r.req.addr, r.req.data});
            chk("accel_on", accel_program_input, r.req.op == nfb_pkg::NFB_OP_ACCEL);
            repeat (5) @(posedge core_clk);
            #1;
            chk("accel_off", {accel_program_input, dq_oe}, 2'b00);
        end
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        clk_en = 1'b1;
        req = '0;
        rows = '{'{'{nfb_pkg::NFB_OP_WRITE, 22'h000123, 16'h1234}, 16'h0000},
                 '{'{nfb_pkg::NFB_OP_WRITE, 22'h3FFFFF, 16'hABCD}, 16'h0000},
                 '{'{nfb_pkg::NFB_OP_ACCEL, 22'h001000, 16'h5A5A}, 16'h0000},
                 '{'{nfb_pkg::NFB_OP_READ, 22'h000123, 16'h0000}, 16'h1234},
                 '{'{nfb_pkg::NFB_OP_READ, 22'h3FFFFF, 16'h0000}, 16'hABCD},
                 '{'{nfb_pkg::NFB_OP_READ, 22'h001000, 16'h0000}, 16'h5A5A},
                 '{'{nfb_pkg::NFB_OP_READ, 22'h200000, 16'h0000}, 16'hFFFF}};
        repeat (3) @(posedge core_clk);
        #1;
        chk("rst_outs", {strobes, dq_oe, accel_program_input, req_ready}, 7'h78);
        @(posedge core_clk);
        rst <= 1'b0;
        $display("test reset done");
        foreach (rows[i]) do_row(rows[i]);
        $display("test table done");
        issue('{nfb_pkg::NFB_OP_CLEAR, 22'h0, 16'h0});
        chk("clear_low", strobes.clear_n, 1'b0);
        wait_pulse(1'b1, n);
        chk("clear_len", n, CLR);
        chk("clear_high", strobes.clear_n, 1'b1);
        do_row(rows[3]);
        $display("test clear done");
        issue('{nfb_pkg::NFB_OP_IDLE, 22'h0, 16'h0});
        repeat (3) @(posedge core_clk);
        #1;
        chk("standby", {strobes.chip_sel_n, accel_program_input}, 2'b10);
        do_row(rows[4]);
        $display("test standby done");
        // Freeze one edge into a read: strobes hold, answer comes late
        issue(rows[5].req);
        @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        chk("frozen", {rd_valid, strobes}, {1'b0, 4'h3});
        @(posedge core_clk);
        clk_en <= 1'b1;
        wait_pulse(1'b0, n);
        chk("frozen_lat", n, nfb_pkg::CE_ACC_CYC + 1);
        chk("frozen_data", rd_data, rows[5].exp);
        $display("test freeze done");
        // Reset in mid accelerated write, then the write is issued again
        issue('{nfb_pkg::NFB_OP_ACCEL, 22'h000200, 16'h0F0F});
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("mid_rst", {strobes, dq_oe, accel_program_input, req_ready}, 7'h78);
        @(posedge core_clk);
        rst <= 1'b0;
        do_row('{'{nfb_pkg::NFB_OP_ACCEL, 22'h000200, 16'h0F0F}, 16'h0000});
        do_row('{'{nfb_pkg::NFB_OP_READ, 22'h000200, 16'h0000}, 16'h0F0F});
        $display("test mid reset done");
        complete_run();
    end
endmodule
